// ==== hw/ispp_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module ispp_sync
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end
      else
      begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// ==== hw/ispp_top.sv ====
// Test-port control, flash status, security and port-enable register
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
module ispp_top
   import ispp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic chip_rst_n,
   input wire logic pin_select_term,
   output logic tdo,
   output logic tdo_oe,
   output logic isp_status_out,
   output logic isp_status_oe,
   output logic isp_error_out,
   output logic isp_error_oe,
   output logic pins_claimed,
   output logic irq
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      ispp_tap_e tap;
      logic [7:0] ir;
      logic [31:0] dr;
      logic tck_q;
      logic tdo;
      logic tdo_oe;
      logic sess;
      logic od;
      logic closed;
      logic err;
      logic sw_en;
      logic [CFG_W-1:0] cfg;
      logic [MEM_AW-1:0] raddr;
      logic [7:0] busy_cnt;
      logic [MEM_BYTES-1:0][7:0] mem;
      logic [NUM_EV-1:0] ists;
      logic [NUM_EV-1:0] ien;
      logic irq;
      logic aw_got;
      logic w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic claimed;
      logic st_out;
      logic st_oe;
      logic er_out;
      logic er_oe;
   } ispp_state_s;

   ispp_state_s s;
   ispp_state_s n;
   logic [3:0] pins;

   ispp_sync #(.W(4), .RST_VAL(4'h8)) u_sync
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({chip_rst_n, tck, tms, tdi}),
      .q(pins)
   );

   wire tck_s = pins[2];
   wire tms_s = pins[1];
   wire tdi_s = pins[0];
   wire chip_rst = !pins[3];

   // ----------------------------------------------------------------------
   // Test-port state walk
   // ----------------------------------------------------------------------
   function automatic ispp_tap_e tap_step(ispp_tap_e t, logic m);
      case (t)
         TAP_RESET: tap_step = m ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: tap_step = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tap_step = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR: tap_step = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: tap_step = m ? TAP_UP_DR : TAP_PA_DR;
         TAP_PA_DR: tap_step = m ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: tap_step = m ? TAP_UP_DR : TAP_SH_DR;
         TAP_UP_DR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: tap_step = m ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: tap_step = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR: tap_step = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: tap_step = m ? TAP_UP_IR : TAP_PA_IR;
         TAP_PA_IR: tap_step = m ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: tap_step = m ? TAP_UP_IR : TAP_SH_IR;
         default: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      logic dedicated;
      logic secured;
      logic busy;
      logic rise;
      logic fall;
      logic blocked;
      logic [NUM_EV-1:0] ev;
      logic [MEM_AW-1:0] addr;
      logic [7:0] pdata;
      logic [3:0] sect;
      logic [9:0] widx;
      logic [9:0] ridx;
      n = s;
      dedicated = s.cfg[CFG_DEDICATE];
      secured = s.cfg[CFG_SECURE];
      busy = (s.busy_cnt != 8'h00);
      rise = tck_s && !s.tck_q;
      fall = !tck_s && s.tck_q;
      blocked = 1'b0;
      ev = '0;
      addr = s.dr[ADDR_LSB +: MEM_AW];
      pdata = s.dr[7:0];
      sect = addr[SECT_LSB +: 4];
      widx = s.awaddr[11:2];
      ridx = s_axi_araddr[11:2];
      n.tck_q = tck_s;

      // Flash cycle timer
      if (busy)
      begin
         n.busy_cnt = s.busy_cnt - 8'h01;
         ev[EV_DONE] = (s.busy_cnt == 8'h01);
      end

      // Pin ownership
      n.claimed = dedicated || s.sw_en || pin_select_term;

      if (!n.claimed || (chip_rst && !dedicated))
      begin
         n.tap = TAP_RESET;
         n.sess = 1'b0;
         if (chip_rst)
         begin
            n.busy_cnt = 8'h00;
         end
      end
      else if (rise)
      begin
         n.tap = tap_step(s.tap, tms_s);
         case (s.tap)
            TAP_RESET:
            begin
               n.ir = IR_CAPTURE;
            end
            TAP_CAP_IR:
            begin
               n.ir = IR_CAPTURE;
            end
            TAP_SH_IR:
            begin
               n.ir = {tdi_s, s.ir[7:1]};
            end
            TAP_CAP_DR:
            begin
               n.dr = 32'h0000_0000;
               if (s.ir == CMD_READ && !secured)
               begin
                  n.dr[7:0] = s.mem[s.raddr];
               end
               else if (s.ir == CMD_READ)
               begin
                  ev[EV_REFUSED] = 1'b1;
               end
            end
            TAP_SH_DR:
            begin
               n.dr = {tdi_s, s.dr[31:1]};
            end
            TAP_UP_DR:
            begin
               if (s.ir == CMD_OPEN)
               begin
                  n.sess = 1'b1;
                  n.closed = 1'b0;
                  n.od = s.dr[OD_BIT];
               end
               else if (!s.sess)
               begin
                  n.sess = 1'b0;
               end
               else if (s.ir == CMD_CLOSE)
               begin
                  n.sess = 1'b0;
                  n.closed = 1'b1;
               end
               else if (s.ir == CMD_CLEAR)
               begin
                  n.err = 1'b0;
               end
               else if (busy)
               begin
                  ev[EV_REFUSED] = 1'b1;
               end
               else if (s.ir == CMD_CHIP_ERASE)
               begin
                  n.mem = {MEM_BYTES{ERASED_BYTE}};
                  n.cfg = CFG_DELIVERED;
                  n.busy_cnt = ERASE_CYC;
               end
               else if (secured)
               begin
                  blocked = 1'b1;
               end
               else if (s.ir == CMD_SECT_ERASE)
               begin
                  if (32'(sect) >= NUM_SECT)
                  begin
                     ev[EV_REFUSED] = 1'b1;
                  end
                  else if (s.cfg[CFG_PROT_LSB + 32'(sect)])
                  begin
                     n.err = 1'b1;
                  end
                  else
                  begin
                     for (int i = 0; i < MEM_BYTES; i++)
                     begin
                        if (i / SECT_BYTES == 32'(sect))
                        begin
                           n.mem[i] = ERASED_BYTE;
                        end
                     end
                     n.busy_cnt = ERASE_CYC;
                  end
               end
               else if (s.ir == CMD_PROGRAM)
               begin
                  if (32'(addr) >= MEM_BYTES)
                  begin
                     ev[EV_REFUSED] = 1'b1;
                  end
                  else
                  begin
                     n.mem[addr] = s.mem[addr] & pdata;
                     if ((s.mem[addr] & pdata) != pdata)
                     begin
                        n.err = 1'b1;
                     end
                     n.busy_cnt = PROG_CYC;
                  end
               end
               else if (s.ir == CMD_READ)
               begin
                  n.raddr = addr;
               end
               else if (s.ir == CMD_CFG_WRITE)
               begin
                  n.cfg = s.cfg | s.dr[CFG_W-1:0];
                  n.busy_cnt = PROG_CYC;
               end
            end
            default:
            begin
               n.ir = s.ir;
            end
         endcase
      end
      else if (fall)
      begin
         n.tdo = (s.tap == TAP_SH_IR) ? s.ir[0] : s.dr[0];
      end
      if (blocked)
      begin
         ev[EV_REFUSED] = 1'b1;
      end
      ev[EV_ERROR] = n.err && !s.err;

      // Error held until clear, or chip reset after close
      if (chip_rst && s.closed)
      begin
         n.err = 1'b0;
         n.closed = 1'b0;
      end

      // Pin drive
      n.tdo_oe = n.claimed && n.sess;
      n.st_out = n.od ? 1'b0 : (n.busy_cnt == 8'h00);
      n.st_oe = n.sess && (!n.od || n.busy_cnt != 8'h00);
      n.er_out = n.od ? 1'b0 : !n.err;
      n.er_oe = n.sess && (!n.od || n.err);

      // ----------------------------------------------------------------
      // Register bus
      // ----------------------------------------------------------------
      if (s_axi_awvalid && s.awready)
      begin
         n.aw_got = 1'b1;
         n.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready)
      begin
         n.w_got = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (s.bvalid && s_axi_bready)
      begin
         n.bvalid = 1'b0;
      end
      if (s.aw_got && s.w_got && !s.bvalid)
      begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = RESP_OKAY;
         if (s.awaddr[1:0] != 2'h0)
         begin
            n.bresp = RESP_SLVERR;
         end
         else if (widx == IDX_PORT_EN)
         begin
            if (s.wstrb[0])
            begin
               n.sw_en = s.wdata[PORT_EN_BIT];
            end
         end
         else if (widx == IDX_IRQ_CLEAR)
         begin
            n.ists = s.ists & ~s.wdata[NUM_EV-1:0];
         end
         else if (widx == IDX_IRQ_ENABLE)
         begin
            if (s.wstrb[0])
            begin
               n.ien = s.wdata[NUM_EV-1:0];
            end
         end
         else if (widx != IDX_IRQ_STATUS && widx != IDX_STATE)
         begin
            n.bresp = RESP_SLVERR;
         end
      end
      n.awready = !n.aw_got && !n.bvalid;
      n.wready = !n.w_got && !n.bvalid;

      if (s.rvalid && s_axi_rready)
      begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s.arready)
      begin
         n.rvalid = 1'b1;
         n.rresp = RESP_OKAY;
         n.rdata = 32'h0000_0000;
         if (s_axi_araddr[1:0] != 2'h0)
         begin
            n.rresp = RESP_SLVERR;
         end
         else if (ridx == IDX_PORT_EN)
         begin
            n.rdata[PORT_EN_BIT] = s.sw_en;
         end
         else if (ridx == IDX_IRQ_STATUS)
         begin
            n.rdata[NUM_EV-1:0] = s.ists;
         end
         else if (ridx == IDX_IRQ_ENABLE)
         begin
            n.rdata[NUM_EV-1:0] = s.ien;
         end
         else if (ridx == IDX_STATE)
         begin
            n.rdata[6:0] = {busy, s.err, secured, s.sess, s.od, s.claimed,
                            dedicated};
         end
         else if (ridx != IDX_IRQ_CLEAR)
         begin
            n.rresp = RESP_SLVERR;
         end
      end
      n.arready = !n.rvalid;

      // Sticky events, set wins over clear
      n.ists = n.ists | ev;
      n.irq = |(n.ists & n.ien);

      // Any device reset drops the software enable
      if (chip_rst)
      begin
         n.sw_en = 1'b0;
      end

      if (!aresetn)
      begin
         n = '0;
         n.tap = TAP_RESET;
         n.ir = IR_CAPTURE;
         n.mem = {MEM_BYTES{ERASED_BYTE}};
         n.cfg = CFG_DELIVERED;
         n.er_out = 1'b1;
         n.st_out = 1'b1;
         n.tck_q = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      s <= n;
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bresp = s.bresp;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_arready = s.arready;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rvalid = s.rvalid;
   assign tdo = s.tdo;
   assign tdo_oe = s.tdo_oe;
   assign isp_status_out = s.st_out;
   assign isp_status_oe = s.st_oe;
   assign isp_error_out = s.er_out;
   assign isp_error_oe = s.er_oe;
   assign pins_claimed = s.claimed;
   assign irq = s.irq;

endmodule

// ==== include/ispp_pkg.sv ====
// Package of constants and types for the test-port status and security block
// What this block does
// - Status extension output is high while both flash arrays sit in read mode.
// - Status extension output is low during any program, erase or array write.
// - Session open may select open-drain; status and error outputs then only pull low.
// - While secured, every memory read attempt is refused.
// - While secured, only full chip erase and the open, close and clear commands are accepted over the test port.
// - Full chip erase clears the security bit and leaves the part blank.
// - Each sector has a protect bit; a sector erase of a protected sector is not done and sets the error flag.
// - Delivered state: every memory array bit reads as one.
// - Delivered state: every configuration register bit is zero.
// - Port-enable bit 0 written one enables the port, zero disables it.
// - With dedicated pins, chip reset never disturbs test-port operations.
// - With software enable only, chip reset aborts and blocks port operations.
// - Pins are claimed by dedicate bit, software enable or pin-select term.
// - Any device reset clears the software enable bit; software may clear it.
// - Error output goes low on failure until clear command or reset after close.
// - Port-enable register sits at index C7h from the control register base.
package ispp_pkg;

   // -------------------------------------------------------------------------
   // Register map (index, byte address is four times the index)
   // -------------------------------------------------------------------------
   localparam logic [9:0] IDX_PORT_EN = 10'h0C7;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h0C8;
   localparam logic [9:0] IDX_IRQ_CLEAR = 10'h0C9;
   localparam logic [9:0] IDX_IRQ_ENABLE = 10'h0CA;
   localparam logic [9:0] IDX_STATE = 10'h0CB;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // -------------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------------
   localparam int PORT_EN_BIT = 0;
   localparam int EV_DONE = 0;
   localparam int EV_ERROR = 1;
   localparam int EV_REFUSED = 2;
   localparam int NUM_EV = 3;
   localparam int CFG_SECURE = 0;
   localparam int CFG_DEDICATE = 1;
   localparam int CFG_PROT_LSB = 2;
   localparam int CFG_W = 16;
   localparam int OD_BIT = 0;
   localparam int ADDR_LSB = 16;

   // -------------------------------------------------------------------------
   // Flash arrays: 8 primary and 4 secondary sectors
   // -------------------------------------------------------------------------
   localparam int NUM_SECT = 12;
   localparam int SECT_BYTES = 4;
   localparam int MEM_BYTES = NUM_SECT * SECT_BYTES;
   localparam int MEM_AW = 6;
   localparam int SECT_LSB = 2;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [CFG_W-1:0] CFG_DELIVERED = 16'h0000;

   // -------------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------------
   localparam int CLK_NS = 8;
   localparam int PROG_TIME_NS = 200;
   localparam int ERASE_TIME_NS = 800;
   localparam logic [7:0] PROG_CYC = 8'((PROG_TIME_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] ERASE_CYC = 8'((ERASE_TIME_NS + CLK_NS - 1) / CLK_NS);

   // -------------------------------------------------------------------------
   // Test-port instructions
   // -------------------------------------------------------------------------
   localparam logic [7:0] IR_CAPTURE = 8'h01;
   localparam logic [7:0] CMD_OPEN = 8'hE8;
   localparam logic [7:0] CMD_CLOSE = 8'hE9;
   localparam logic [7:0] CMD_CLEAR = 8'hEA;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'hEB;
   localparam logic [7:0] CMD_SECT_ERASE = 8'hEC;
   localparam logic [7:0] CMD_PROGRAM = 8'hED;
   localparam logic [7:0] CMD_READ = 8'hEE;
   localparam logic [7:0] CMD_CFG_WRITE = 8'hEF;

   typedef enum logic [3:0] {
      TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
      TAP_SH_DR = 4'h6, TAP_EX1_DR = 4'h7, TAP_PA_DR = 4'h5,
      TAP_EX2_DR = 4'h4, TAP_UP_DR = 4'hC, TAP_SEL_IR = 4'hD,
      TAP_CAP_IR = 4'hF, TAP_SH_IR = 4'hE, TAP_EX1_IR = 4'hA,
      TAP_PA_IR = 4'hB, TAP_EX2_IR = 4'h9, TAP_UP_IR = 4'h8
   } ispp_tap_e;

endpackage

// ==== testbench/ispp_chk_sva.sv ====
// Port checker for the test-port status block
`timescale 1ns/1ns
module ispp_chk
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic pin_select_term,
   input wire logic pins_claimed,
   input wire logic tdo_oe,
   input wire logic isp_status_out,
   input wire logic isp_status_oe
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_aw_take;
      s_axi_awvalid && s_axi_awready;
   endsequence
   sequence s_busy;
      $fell(isp_status_out) && isp_status_oe;
   endsequence
   property p_wr;
      s_aw_take |-> ##[1:4] s_axi_bvalid;
   endproperty
   a_wr: assert property (p_wr) else $error("write response missing");
   property p_bdone;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_bdone: assert property (p_bdone) else $error("write response repeated");
   property p_rd;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd: assert property (p_rd) else $error("read data late");
   property p_claim;
      pin_select_term |-> ##[0:3] pins_claimed;
   endproperty
   a_claim: assert property (p_claim) else $error("pins not claimed");
   property p_tdo;
      !pins_claimed [*3] |-> !tdo_oe;
   endproperty
   a_tdo: assert property (p_tdo) else $error("tdo driven unclaimed");
   property p_busy_min;
      s_busy |-> !isp_status_out [*8];
   endproperty
   a_busy_min: assert property (p_busy_min) else $error("busy too short");
   property p_busy_max;
      s_busy |-> ##[1:1000] isp_status_out;
   endproperty
   a_busy_max: assert property (p_busy_max) else $error("busy stuck");
   property p_rst;
      $rose(aresetn) |-> isp_status_out && !pins_claimed;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
endmodule
bind ispp_top ispp_chk i_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .pin_select_term(pin_select_term),
   .pins_claimed(pins_claimed), .tdo_oe(tdo_oe),
   .isp_status_out(isp_status_out), .isp_status_oe(isp_status_oe));

// ==== testbench/ispp_tap_model.sv ====
// Model of the external test-port controller
`timescale 1ns/1ns
module ispp_tap_model
(
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   initial
   begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h0;
   end
   // One period; the clock rests low between scans
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #63 tck = 1'h1;
      o = tdo;
      #62 tck = 1'h0;
   endtask
   task automatic reset_tap();
      logic o;
      repeat (5) step(1'h1, 1'h0, o);
      step(1'h0, 1'h0, o);
   endtask
   // Shift n bits LSB first, update, back to idle
   task automatic scan(input logic ir, input logic [31:0] v, input int n,
      output logic [31:0] q);
      logic o;
      q = 32'h0;
      step(1'h1, 1'h0, o);
      if (ir)
         step(1'h1, 1'h0, o);
      step(1'h0, 1'h0, o);
      step(1'h0, 1'h0, o);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, v[i], o);
         q[i] = o;
      end
      step(1'h1, 1'h0, o);
      step(1'h0, 1'h0, o);
      // Released data line: inverse of the zero left by the idle step, so high
      tdi = ~tdi;
   endtask
   task automatic cmd(input logic [7:0] c, input logic [31:0] v,
      output logic [31:0] q);
      scan(1'h1, {24'h0, c}, 8, q);
      scan(1'h0, v, 32, q);
   endtask
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the test-port status block
`timescale 1ns/1ns
module tb_top;
   import ispp_pkg::*;
   logic aclk, aresetn = 1'h0, chip_rst_n = 1'h1, sel = 1'h0;
   logic aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
   logic aw_r, w_r, b_v, ar_r, r_v, tck, tms, tdi, tdo, st, st_oe, er;
   logic claimed, irq, er_oe;
   logic [11:0] aw_a = 12'h000, ar_a = 12'h000;
   logic [31:0] w_d = 32'h0, r_d, q, rng = 32'h8770;
   logic [1:0] b_resp, r_resp, rsp;
   logic [5:0] ad [4];
   logic [7:0] dt [4];
   int error_cnt = 0, check_count = 0, cyc = 0;
   ispp_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a),
      .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
      .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
      .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
      .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
      .s_axi_rready(r_r), .tck(tck), .tms(tms), .tdi(tdi),
      .chip_rst_n(chip_rst_n), .pin_select_term(sel), .tdo(tdo),
      .tdo_oe(), .isp_status_out(st), .isp_status_oe(st_oe),
      .isp_error_out(er), .isp_error_oe(er_oe), .pins_claimed(claimed),
      .irq(irq));
   ispp_tap_model i_tap (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
   initial
   begin
      aclk = 1'h0;
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         error_cnt = error_cnt + 1;
         close_out();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   function automatic logic [31:0] dr(input logic [5:0] a, input logic [7:0] d);
      return {10'h000, a, 8'h00, d};
   endfunction
   function automatic logic [7:0] cell_exp(input logic sec, input logic [7:0] c);
      return sec ? 8'h00 : c;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      @(posedge aclk);
      aw_a <= {idx, 2'h0};
      w_d <= d;
      aw_v <= 1'h1;
      w_v <= 1'h1;
      b_r <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (aw_r) aw_v <= 1'h0;
         if (w_r) w_v <= 1'h0;
      end
      while (b_v !== 1'h1);
      rsp = b_resp;
      b_r <= 1'h0;
   endtask
   task automatic rd(input logic [9:0] idx);
      @(posedge aclk);
      ar_a <= {idx, 2'h0};
      ar_v <= 1'h1;
      r_r <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (ar_r) ar_v <= 1'h0;
      end
      while (r_v !== 1'h1);
      q = r_d;
      rsp = r_resp;
      r_r <= 1'h0;
   endtask
   task automatic rdcell(input logic [5:0] a);
      i_tap.cmd(CMD_READ, dr(a, 8'h00), q);
      i_tap.scan(1'h0, 32'h0, 32, q);
   endtask
   task automatic wait_ready();
      for (int i = 0; i < 2000 && st === 1'h0 && st_oe === 1'h1; i++)
         @(posedge aclk);
   endtask
   task automatic pulse_rst();
      @(posedge aclk);
      chip_rst_n <= 1'h0;
      repeat (8) @(posedge aclk);
      chip_rst_n <= 1'h1;
      repeat (4) @(posedge aclk);
   endtask
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (3) @(posedge aclk);
      rd(IDX_PORT_EN);
      chk(q, 32'h0);
      rd(IDX_STATE);
      chk(q, 32'h0);
      $display("reset test done");
      wr(IDX_PORT_EN, 32'hFF);
      rd(IDX_PORT_EN);
      chk(q, 32'h1);
      chk(claimed, 1'h1);
      wr(IDX_PORT_EN, 32'h0);
      rd(IDX_STATE);
      chk(q[1], 1'h0);
      sel <= 1'h1;
      rd(IDX_STATE);
      chk(q[1], 1'h1);
      sel <= 1'h0;
      wr(10'h3FF, 32'h0);
      chk(rsp, RESP_SLVERR);
      rd(10'h3FF);
      chk({rsp, q[29:0]}, {RESP_SLVERR, 30'h0});
      wr(IDX_PORT_EN, 32'h1);
      wr(IDX_IRQ_ENABLE, 32'h7);
      $display("register test done");
      i_tap.reset_tap();
      i_tap.cmd(CMD_OPEN, 32'h0, q);
      for (int i = 0; i < 4; i++)
      begin
         rng = xs(rng);
         ad[i] = {1'h0, i[1:0], 1'h0, rng[1:0]};
         dt[i] = rng[15:8];
         rdcell(ad[i]);
         chk(q[7:0], cell_exp(1'h0, ERASED_BYTE));
         i_tap.cmd(CMD_PROGRAM, dr(ad[i], dt[i]), q);
         chk(st, 1'h0);
         wait_ready();
         chk(st, 1'h1);
         rdcell(ad[i]);
         chk(q[7:0], cell_exp(1'h0, dt[i]));
      end
      chk(irq, 1'h1);
      wr(IDX_IRQ_ENABLE, 32'h6);
      rd(IDX_IRQ_STATUS);
      chk({irq, q[2:0]}, 4'h1);
      wr(IDX_IRQ_CLEAR, 32'h7);
      wr(IDX_IRQ_ENABLE, 32'h7);
      $display("program test done");
      i_tap.cmd(CMD_CFG_WRITE, 32'h4, q);
      i_tap.cmd(CMD_SECT_ERASE, dr(6'h00, 8'h00), q);
      chk({st, er, er_oe}, 3'h5);
      rdcell(ad[0]);
      chk(q[7:0], dt[0]);
      i_tap.cmd(CMD_SECT_ERASE, dr(6'h08, 8'h00), q);
      wait_ready();
      rdcell(ad[1]);
      chk({er, q[7:0]}, {1'h0, ERASED_BYTE});
      i_tap.cmd(CMD_CLEAR, 32'h0, q);
      chk(er, 1'h1);
      $display("protect test done");
      i_tap.cmd(CMD_CFG_WRITE, 32'h1, q);
      rdcell(ad[0]);
      chk(q[7:0], cell_exp(1'h1, dt[0]));
      i_tap.cmd(CMD_PROGRAM, dr(6'h20, 8'h00), q);
      rd(IDX_IRQ_STATUS);
      chk({st, q[2]}, 2'h3);
      i_tap.cmd(CMD_CHIP_ERASE, 32'h0, q);
      chk(st, 1'h0);
      wait_ready();
      rd(IDX_STATE);
      chk(q[4], 1'h0);
      rdcell(ad[0]);
      chk(q[7:0], ERASED_BYTE);
      $display("security test done");
      i_tap.cmd(CMD_CLOSE, 32'h0, q);
      i_tap.cmd(CMD_OPEN, 32'h1, q);
      chk({st, st_oe, er_oe}, 3'h0);
      i_tap.cmd(CMD_PROGRAM, dr(6'h21, 8'h5A), q);
      chk({st, st_oe}, 2'h1);
      wait_ready();
      chk({st, st_oe}, 2'h0);
      i_tap.cmd(CMD_PROGRAM, dr(6'h21, 8'hFF), q);
      chk(er_oe, 1'h1);
      i_tap.cmd(CMD_CLOSE, 32'h0, q);
      $display("open-drain test done");
      pulse_rst();
      rd(IDX_PORT_EN);
      chk(q, 32'h0);
      rd(IDX_STATE);
      chk({q[5], q[3]}, 2'h0);
      wr(IDX_PORT_EN, 32'h1);
      i_tap.reset_tap();
      i_tap.cmd(CMD_OPEN, 32'h0, q);
      i_tap.cmd(CMD_CFG_WRITE, 32'h2, q);
      pulse_rst();
      rd(IDX_STATE);
      chk(q[3:0], 4'hB);
      $display("chip reset test done");
      close_out();
   end
endmodule
